// ===== rtl/vfd_pkg.sv
// Package holding constants and types of the frame tail and line diagnosis block
// Operation
// - CRC preset all ones, inverted before send
// - CRC over identifier, command, data automatically
// - After CRC: end-of-data, acknowledge, end-of-frame
// - Data frame: originator only, receiver acknowledges
// - Immediate reply: replier drives remote bit onward; here replier drives from the data field on
// - Deferred request: requester finishes, requested acknowledges
// - Deferred reply: data frame, read/write inverted
// - Deferred reply: command bits fixed, receiver acknowledges
// - Three receive inputs: differential, true, complement
// - Generate return-to-idle, diagnosis clock, tx-in-progress
// - One wire fault: degraded, route healthy wire
// - Wire healthy again: nominal, differential routed
// - Both wires faulty: major error
// - Return: idle pulse, or two clean clocks; here manual mode also returns on any rising diagnosis clock edge
// - Status bits always show current diagnosis
// - Line state encoding 00,01,10,11
// - Major error: alternate wires each clock period
// - Mismatch flag set on any input disagreement
// - Mismatch cleared only by idle pulse, reset
// - Idle pulse at end of frame, not automatic
// - Eight dominant timeslots: major error
// - Four edges versus none: silent wire faulty
package vfd_pkg;

    // ****************************************************************
    // CRC constants
    // ****************************************************************
    localparam int unsigned  CRC_W    = 15;        // Check sequence width
    localparam logic [14:0]  CRC_INIT = 15'h7fff;  // Remainder preset
    localparam logic [14:0]  CRC_POLY = 15'h0f9d;  // x11..x0 taps of g(x)

    // ****************************************************************
    // Diagnosis constants
    // ****************************************************************
    localparam logic [3:0]   DOM_LIMIT  = 4'h8;    // Consecutive dominant timeslots
    localparam logic [2:0]   EDGE_LIMIT = 3'h4;    // Edges against a silent wire
    localparam logic [1:0]   CLEAN_SDC  = 2'h2;    // Clean diagnosis edges to recover
    localparam logic [15:0]  SDC_DIV    = 16'h0100; // Timeslots per diagnosis clock half period
    localparam logic [1:0]   LS_NOMINAL = 2'h0;    // Line state codes
    localparam logic [1:0]   LS_CMP_BAD = 2'h1;
    localparam logic [1:0]   LS_TRU_BAD = 2'h2;
    localparam logic [1:0]   LS_MAJOR   = 2'h3;

    // ****************************************************************
    // Register map of the plain port
    // ****************************************************************
    localparam logic [3:0]   REG_CTRL   = 4'h0;    // Mode and manual clock
    localparam logic [3:0]   REG_STAT   = 4'h1;    // Diagnosis status
    localparam logic [3:0]   REG_TXCMD  = 4'h2;    // Frame kind and ack request
    localparam logic [3:0]   REG_CRCLO  = 4'h3;    // Check sequence low
    localparam logic [3:0]   REG_CRCHI  = 4'h4;    // Check sequence high

    // Frame kinds
    typedef enum logic [1:0] {
        VFD_FR_DATA,
        VFD_FR_REQ_IMM,
        VFD_FR_REQ_DEF,
        VFD_FR_DEF_REPLY
    } vfd_kind_t;

    // Frame field phases seen by the tail sequencer
    typedef enum logic [2:0] {
        VFD_PH_IDLE,
        VFD_PH_HEAD,
        VFD_PH_DATA,
        VFD_PH_FCS,
        VFD_PH_EOD,
        VFD_PH_ACK,
        VFD_PH_EOF
    } vfd_phase_t;

    // Diagnosis states
    typedef enum logic [1:0] {
        VFD_DG_NOMINAL,
        VFD_DG_CMP_BAD,
        VFD_DG_TRU_BAD,
        VFD_DG_MAJOR
    } vfd_diag_t;

endpackage

// ===== rtl/vfd_crc.sv
// Serial frame check sequence generator
`timescale 1ns/1ps
module vfd_crc (
    input  wire logic        clock_i,   // System clock
    input  wire logic        nrst_i,    // Synchronous reset, low active
    input  wire logic        init_i,    // Preset remainder
    input  wire logic        bit_en_i,  // Shift one bit in
    input  wire logic        bit_i,     // Serial data bit
    output logic [14:0]      fcs_o      // Inverted check bits
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [14:0] rem;               // Division remainder
    } vfd_crc_st_t;

    vfd_crc_st_t s_q;                   // Registered state
    vfd_crc_st_t s_d;                   // Next state

    // Remainder update per incoming bit
    always_comb begin
        logic fb;
        fb  = 1'b0;
        s_d = s_q;
        if (init_i) begin
            s_d.rem = vfd_pkg::CRC_INIT;
        end else if (bit_en_i) begin
            fb      = s_q.rem[14] ^ bit_i;
            s_d.rem = {s_q.rem[13:0], 1'b0} ^ (fb ? vfd_pkg::CRC_POLY : 15'h0000);
        end
    end

    // State register
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            s_q.rem <= vfd_pkg::CRC_INIT;
        end else begin
            s_q <= s_d;
        end
    end

    // Check bits go out inverted
    assign fcs_o = ~s_q.rem;

endmodule

// ===== rtl/vfd_top.sv
// Frame tail sequencer and line diagnosis of the bus controller
`timescale 1ns/1ps
module vfd_top (
    input  wire logic        clock_i,        // 25 MHz clock
    input  wire logic        nrst_i,         // Synchronous reset, low active
    input  wire logic        ts_tick_i,      // One pulse per timeslot
    input  wire logic        rx_differential_i,  // Differential receiver
    input  wire logic        rx_true_wire_i,     // True wire receiver
    input  wire logic        rx_complement_wire_i, // Complement wire receiver
    input  wire logic        tx_bit_i,       // Transmit logic output level
    input  wire logic        frame_start_i,  // Start of identifier field
    input  wire logic        data_end_i,     // Last data bit sent or seen
    input  wire logic        field_done_i,   // Current tail field finished
    input  wire logic        bit_en_i,       // Bit strobe for the check sequence
    input  wire logic        eof_i,          // End of frame detected
    input  wire logic [3:0]  addr_i,         // Register address
    input  wire logic [7:0]  wdata_i,        // Write data
    input  wire logic        wr_i,           // Write strobe
    input  wire logic        rd_i,           // Read strobe
    output logic [7:0]       rdata_o,        // Read data, one cycle later
    output logic             rx_sel_o,       // Level routed to reception
    output logic             drive_en_o,     // This end drives current field
    output logic             cmd_rw_o,       // Read/write command bit to send
    output logic             fcs_bit_o,      // Check bit being sent
    output logic [2:0]       phase_o,        // Current frame phase
    output logic             tx_in_progress_o, // Transmission in progress
    output logic             line_state_hi_o,  // Line state high bit
    output logic             line_state_lo_o,  // Line state low bit
    output logic             input_mismatch_flag_o // Input mismatch flag
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        vfd_pkg::vfd_phase_t phase;     // Frame phase
        vfd_pkg::vfd_diag_t  diag;      // Diagnosis state
        vfd_pkg::vfd_kind_t  kind;      // Frame kind
        logic        originator;        // This end opened the frame
        logic        ack_req;           // Acknowledge requested
        logic        auto_mode;         // Automatic selection mode
        logic        sdc_manual;        // Manual diagnosis clock level
        logic        sdc_int;           // Internal diagnosis clock level
        logic        sdc_prev;          // Previous diagnosis clock level
        logic [15:0] sdc_cnt;           // Diagnosis clock divider
        logic [1:0]  clean_cnt;         // Clean diagnosis edges seen
        logic        fault_seen;        // Fault during this period
        logic        major_wire;        // Major error: 0 true, 1 complement
        logic [3:0]  dom_cnt;           // Consecutive dominant timeslots
        logic [2:0]  e_tru;             // Edges on true wire
        logic [2:0]  e_cmp;             // Edges on complement wire
        logic        tru_prev;          // Last true wire level
        logic        cmp_prev;          // Last complement wire level
        logic        mismatch;          // Input mismatch flag
        logic        ri;                // Return-to-idle pulse
        logic [3:0]  fcs_idx;           // Check bit index
        logic [7:0]  rdata;             // Read data
        logic        rx_sel;            // Routed level
        logic        drive_en;          // Drive enable
        logic        tx_in_progress;               // Transmission in progress
    } vfd_st_t;

    vfd_st_t s_q;                       // Registered state
    vfd_st_t s_d;                       // Next state
    logic [14:0] frame_check_seq;                   // Inverted check bits
    logic        crc_init;              // Preset at frame start
    logic        crc_shift;             // Shift during covered fields

    // ****************************************************************
    // Check sequence generator
    // ****************************************************************
    assign crc_init  = frame_start_i;
    assign crc_shift = bit_en_i && (s_q.phase == vfd_pkg::VFD_PH_HEAD ||
                                    s_q.phase == vfd_pkg::VFD_PH_DATA);

    vfd_crc u_crc (
        .clock_i  (clock_i),
        .nrst_i   (nrst_i),
        .init_i   (crc_init),
        .bit_en_i (crc_shift),
        .bit_i    (tx_bit_i),
        .fcs_o    (frame_check_seq)
    );

    // True when the given edge count reaches the edge limit
    function automatic logic edges_full(input logic [2:0] n);
        edges_full = (n >= vfd_pkg::EDGE_LIMIT);
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic sdc_rise;
        logic ri_now;
        logic mis_now;
        logic tru_fault;
        logic cmp_fault;
        logic drv;
        sdc_rise  = 1'b0;
        ri_now    = 1'b0;
        mis_now   = 1'b0;
        tru_fault = 1'b0;
        cmp_fault = 1'b0;
        drv       = 1'b0;
        s_d       = s_q;

        // Register writes
        if (wr_i) begin
            case (addr_i)
                vfd_pkg::REG_CTRL: begin
                    s_d.auto_mode  = wdata_i[0];
                    s_d.sdc_manual = wdata_i[1];
                end
                vfd_pkg::REG_TXCMD: begin
                    s_d.kind       = vfd_pkg::vfd_kind_t'(wdata_i[1:0]);
                    s_d.ack_req    = wdata_i[2];
                    s_d.originator = wdata_i[3];
                end
                default: begin
                end
            endcase
        end

        // Reads have no side effect on status
        s_d.rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                vfd_pkg::REG_CTRL:  s_d.rdata = {6'h00, s_q.sdc_manual, s_q.auto_mode};
                vfd_pkg::REG_STAT:  s_d.rdata = {5'h00, s_q.mismatch, s_q.diag};
                vfd_pkg::REG_TXCMD: s_d.rdata = {4'h0, s_q.originator, s_q.ack_req, s_q.kind};
                vfd_pkg::REG_CRCLO: s_d.rdata = frame_check_seq[7:0];
                vfd_pkg::REG_CRCHI: s_d.rdata = {1'b0, frame_check_seq[14:8]};
                default:            s_d.rdata = 8'h00;
            endcase
        end

        // Frame tail ordering
        case (s_q.phase)
            vfd_pkg::VFD_PH_IDLE: if (frame_start_i) s_d.phase = vfd_pkg::VFD_PH_HEAD;
            vfd_pkg::VFD_PH_HEAD: if (field_done_i)  s_d.phase = vfd_pkg::VFD_PH_DATA;
            vfd_pkg::VFD_PH_DATA: if (data_end_i) begin
                s_d.phase   = vfd_pkg::VFD_PH_FCS;
                s_d.fcs_idx = 4'he;
            end
            vfd_pkg::VFD_PH_FCS: if (bit_en_i) begin
                if (s_q.fcs_idx == 4'h0) s_d.phase = vfd_pkg::VFD_PH_EOD;
                else s_d.fcs_idx = s_q.fcs_idx - 4'h1;
            end
            vfd_pkg::VFD_PH_EOD:  if (field_done_i) s_d.phase = vfd_pkg::VFD_PH_ACK;
            vfd_pkg::VFD_PH_ACK:  if (field_done_i) s_d.phase = vfd_pkg::VFD_PH_EOF;
            vfd_pkg::VFD_PH_EOF:  if (field_done_i) s_d.phase = vfd_pkg::VFD_PH_IDLE;
            default:              s_d.phase = vfd_pkg::VFD_PH_IDLE;
        endcase

        // Which party drives the current field
        case (s_q.kind)
            vfd_pkg::VFD_FR_DATA, vfd_pkg::VFD_FR_DEF_REPLY: begin
                // Originator sends all but the acknowledge; receiver only acknowledges
                drv = (s_q.phase == vfd_pkg::VFD_PH_ACK) ?
                      (!s_q.originator && s_q.ack_req) : s_q.originator;
            end
            vfd_pkg::VFD_FR_REQ_IMM: begin
                // Initiator: head and ack; replier: data onward
                drv = (s_q.phase == vfd_pkg::VFD_PH_HEAD ||
                       s_q.phase == vfd_pkg::VFD_PH_ACK) ? s_q.originator
                                                         : !s_q.originator;
            end
            vfd_pkg::VFD_FR_REQ_DEF: begin
                // Requester keeps going; requested end only acknowledges
                drv = (s_q.phase == vfd_pkg::VFD_PH_ACK) ?
                      (!s_q.originator && s_q.ack_req) : s_q.originator;
            end
            default: drv = 1'b0;
        endcase
        s_d.drive_en = drv && (s_q.phase != vfd_pkg::VFD_PH_IDLE);
        s_d.tx_in_progress      = s_d.drive_en;

        // Return-to-idle pulse, suppressed in automatic mode
        ri_now = eof_i && !s_q.auto_mode;
        s_d.ri = ri_now;

        // Diagnosis clock from divider or manual bit
        if (ts_tick_i) begin
            if (s_q.sdc_cnt == vfd_pkg::SDC_DIV - 16'h0001) begin
                s_d.sdc_cnt = 16'h0000;
                s_d.sdc_int = !s_q.sdc_int;
            end else begin
                s_d.sdc_cnt = s_q.sdc_cnt + 16'h0001;
            end
        end
        s_d.sdc_prev = s_q.sdc_int ^ s_q.sdc_manual;
        sdc_rise     = (s_q.sdc_int ^ s_q.sdc_manual) && !s_q.sdc_prev;

        // Input comparison of the three receivers
        mis_now = (rx_differential_i != rx_true_wire_i) ||
                  (rx_true_wire_i != rx_complement_wire_i);
        if (mis_now) s_d.mismatch = 1'b1;
        else if (s_q.ri) s_d.mismatch = 1'b0;

        // Edge counts per wire, reset every diagnosis period
        s_d.tru_prev = rx_true_wire_i;
        s_d.cmp_prev = rx_complement_wire_i;
        if (rx_true_wire_i != s_q.tru_prev && !edges_full(s_q.e_tru))
            s_d.e_tru = s_q.e_tru + 3'h1;
        if (rx_complement_wire_i != s_q.cmp_prev && !edges_full(s_q.e_cmp))
            s_d.e_cmp = s_q.e_cmp + 3'h1;
        tru_fault = edges_full(s_q.e_cmp) && s_q.e_tru == 3'h0;
        cmp_fault = edges_full(s_q.e_tru) && s_q.e_cmp == 3'h0;

        // Dominant timeslot run on the differential input
        if (ts_tick_i) begin
            if (!rx_differential_i && s_q.dom_cnt != vfd_pkg::DOM_LIMIT)
                s_d.dom_cnt = s_q.dom_cnt + 4'h1;
            else if (rx_differential_i)
                s_d.dom_cnt = 4'h0;
        end

        if (tru_fault || cmp_fault || mis_now) s_d.fault_seen = 1'b1;

        // Diagnosis state transitions
        if (s_q.dom_cnt == vfd_pkg::DOM_LIMIT || (tru_fault && cmp_fault)) begin
            s_d.diag = vfd_pkg::VFD_DG_MAJOR;
        end else if (tru_fault && s_q.diag == vfd_pkg::VFD_DG_NOMINAL) begin
            s_d.diag = vfd_pkg::VFD_DG_TRU_BAD;
        end else if (cmp_fault && s_q.diag == vfd_pkg::VFD_DG_NOMINAL) begin
            s_d.diag = vfd_pkg::VFD_DG_CMP_BAD;
        end else if ((tru_fault && s_q.diag == vfd_pkg::VFD_DG_CMP_BAD) ||
                     (cmp_fault && s_q.diag == vfd_pkg::VFD_DG_TRU_BAD)) begin
            s_d.diag = vfd_pkg::VFD_DG_MAJOR;
        end else if (!s_q.auto_mode && (s_q.ri || sdc_rise)) begin
            s_d.diag = vfd_pkg::VFD_DG_NOMINAL;
        end else if (s_q.auto_mode && sdc_rise && !s_q.fault_seen &&
                     s_q.clean_cnt == vfd_pkg::CLEAN_SDC - 2'h1) begin
            s_d.diag = vfd_pkg::VFD_DG_NOMINAL;
        end

        // Per-period bookkeeping at each rising diagnosis clock edge
        if (sdc_rise) begin
            s_d.clean_cnt  = s_q.fault_seen ? 2'h0 :
                             (s_q.clean_cnt == vfd_pkg::CLEAN_SDC - 2'h1) ? 2'h0 :
                             s_q.clean_cnt + 2'h1;
            s_d.fault_seen = 1'b0;
            s_d.major_wire = !s_q.major_wire;
        end

        // Edge counts restart each period and on return to idle
        if (sdc_rise || s_q.ri) begin
            s_d.e_tru = 3'h0;
            s_d.e_cmp = 3'h0;
        end

        // Route a receiver to the reception logic
        case (s_q.diag)
            vfd_pkg::VFD_DG_NOMINAL: s_d.rx_sel = rx_differential_i;
            vfd_pkg::VFD_DG_TRU_BAD: s_d.rx_sel = rx_complement_wire_i;
            vfd_pkg::VFD_DG_CMP_BAD: s_d.rx_sel = rx_true_wire_i;
            vfd_pkg::VFD_DG_MAJOR:   s_d.rx_sel = s_q.major_wire ?
                                     rx_complement_wire_i : rx_true_wire_i;
            default:                 s_d.rx_sel = rx_differential_i;
        endcase
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            s_q            <= '0;
            s_q.phase      <= vfd_pkg::VFD_PH_IDLE;
            s_q.diag       <= vfd_pkg::VFD_DG_NOMINAL;
            s_q.kind       <= vfd_pkg::VFD_FR_DATA;
            s_q.rx_sel     <= 1'b1;
            s_q.tru_prev   <= 1'b1;
            s_q.cmp_prev   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign rdata_o               = s_q.rdata;
    assign rx_sel_o              = s_q.rx_sel;
    assign drive_en_o            = s_q.drive_en;
    assign cmd_rw_o              = (s_q.kind != vfd_pkg::VFD_FR_DATA);
    assign fcs_bit_o             = frame_check_seq[s_q.fcs_idx];
    assign phase_o               = s_q.phase;
    assign tx_in_progress_o      = s_q.tx_in_progress;
    assign line_state_hi_o       = s_q.diag[1];
    assign line_state_lo_o       = s_q.diag[0];
    assign input_mismatch_flag_o = s_q.mismatch;

endmodule

// ===== bench/vfd_line_model.sv
// Behavioural model of the three bus line receivers
`timescale 1ns/1ps
module vfd_line_model (
    input  wire logic       bit_i,     // Bus level, 1 is recessive
    input  wire logic [1:0] fault_i,   // Bit0 complement wire, bit1 true wire broken
    output logic            rx_diff_o, // Differential receiver
    output logic            rx_tru_o,  // True wire receiver
    output logic            rx_cmp_o   // Complement wire receiver
);
    // A broken wire reads recessive; differential fails only with both gone
    always_comb begin
        rx_tru_o  = fault_i[1] | bit_i;
        rx_cmp_o  = fault_i[0] | bit_i;
        rx_diff_o = (&fault_i) | bit_i;
    end
endmodule

// ===== bench/vfd_top_assertions.sv
// Port checker of the diagnosis block
`timescale 1ns/1ps
module vfd_top_chk (
    input wire logic       clock_i,               // Clock
    input wire logic       nrst_i,                // Reset, low active
    input wire logic       rx_differential_i,     // Differential receiver
    input wire logic       rx_true_wire_i,        // True wire receiver
    input wire logic       rx_complement_wire_i,  // Complement wire receiver
    input wire logic       eof_i,                 // End of frame
    input wire logic [3:0] addr_i,                // Register address
    input wire logic       rd_i,                  // Read strobe
    input wire logic [7:0] rdata_o,               // Read data
    input wire logic       rx_sel_o,              // Routed level
    input wire logic [2:0] phase_o,               // Frame phase
    input wire logic       line_state_hi_o,       // Line state high bit
    input wire logic       line_state_lo_o,       // Line state low bit
    input wire logic       input_mismatch_flag_o  // Mismatch flag
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    wire [1:0] ls    = {line_state_hi_o, line_state_lo_o}; // Line state code
    wire       agree = (rx_differential_i == rx_true_wire_i)
                    && (rx_true_wire_i == rx_complement_wire_i); // Receivers agree
    property p_mis_set; !agree |=> input_mismatch_flag_o; endproperty
    a_mis_set: assert property (p_mis_set) else $error("mismatch flag not set");
    property p_mis_hold;
        input_mismatch_flag_o && !eof_i && !$past(eof_i) |=> input_mismatch_flag_o;
    endproperty
    a_mis_hold: assert property (p_mis_hold) else $error("mismatch flag lost");
    property p_rd_idle; !rd_i |=> rdata_o == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_stat;
        rd_i && addr_i == vfd_pkg::REG_STAT |=>
            rdata_o == {5'h00, $past(input_mismatch_flag_o), $past(ls)};
    endproperty
    a_stat: assert property (p_stat) else $error("status read differs");
    property p_phase;
        $changed(phase_o) && phase_o != 3'h0 |-> phase_o == $past(phase_o) + 3'h1;
    endproperty
    a_phase: assert property (p_phase) else $error("frame field order broken");
    property p_nom; ls == 2'h0 ##1 ls == 2'h0 |-> rx_sel_o == $past(rx_differential_i); endproperty
    a_nom: assert property (p_nom) else $error("nominal route wrong");
    property p_cmp_bad; ls == 2'h1 ##1 ls == 2'h1 |-> rx_sel_o == $past(rx_true_wire_i); endproperty
    a_cmp_bad: assert property (p_cmp_bad) else $error("true wire not routed");
    property p_tru_bad;
        ls == 2'h2 ##1 ls == 2'h2 |-> rx_sel_o == $past(rx_complement_wire_i);
    endproperty
    a_tru_bad: assert property (p_tru_bad) else $error("complement not routed");
endmodule
bind vfd_top vfd_top_chk u_chk (.*);

// ===== bench/tb_van_frame_tail_and_line_diagnosis.sv
// Self-checking bench of the frame tail and line diagnosis block
`timescale 1ns/1ps
module tb_van_frame_tail_and_line_diagnosis;
    // ****************************************************************
    // Stimulus and observation
    // ****************************************************************
    logic        clock_i = 1'b0;   // 25 MHz clock
    logic        nrst_i  = 1'b0;   // Reset, low active
    logic        tick    = 1'b0;   // Timeslot pulse
    logic [1:0]  tcnt    = 2'h0;   // Timeslot divider
    logic        bus_bit = 1'b1;   // Bus level, idle recessive
    logic [1:0]  fault   = 2'h0;   // Broken wires
    logic        tx_bit  = 1'b1;   // Check sequence input
    logic [4:0]  pls     = 5'h00;  // Frame event strobes
    logic [3:0]  addr    = 4'h0;   // Register address
    logic [7:0]  wdata   = 8'h00;  // Write data
    logic        wr      = 1'b0;   // Write strobe
    logic        rd      = 1'b0;   // Read strobe
    logic        rd_seen = 1'b0;   // Read data due
    logic        rx_d, rx_t, rx_c; // Receiver levels
    logic        rx_sel, drive_en, cmd_rw, fcs_bit, tx_in_progress, ls_hi, ls_lo, mis; // Outputs
    logic [7:0]  rdata;            // Read data
    logic [2:0]  phase;            // Frame phase
    logic [7:0]  expq[$];          // Expected read data
    logic [14:0] crc;              // Reference remainder
    int          miscompares     = 0; // Mismatches
    int          samples_checked = 0; // Comparisons
    always #20 clock_i = ~clock_i;
    // Timeslot pulses
    always @(posedge clock_i) begin
        tcnt <= tcnt + 2'h1;
        tick <= (tcnt == 2'h0);
    end
    vfd_line_model u_line (.bit_i(bus_bit), .fault_i(fault), .rx_diff_o(rx_d),
        .rx_tru_o(rx_t), .rx_cmp_o(rx_c));
    vfd_top dut (.clock_i(clock_i), .nrst_i(nrst_i), .ts_tick_i(tick),
        .rx_differential_i(rx_d), .rx_true_wire_i(rx_t), .rx_complement_wire_i(rx_c),
        .tx_bit_i(tx_bit), .frame_start_i(pls[0]), .data_end_i(pls[1]),
        .field_done_i(pls[2]), .bit_en_i(pls[3]), .eof_i(pls[4]), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rx_sel_o(rx_sel),
        .drive_en_o(drive_en), .cmd_rw_o(cmd_rw), .fcs_bit_o(fcs_bit), .phase_o(phase),
        .tx_in_progress_o(tx_in_progress), .line_state_hi_o(ls_hi), .line_state_lo_o(ls_lo),
        .input_mismatch_flag_o(mis));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
        @(posedge clock_i);
    endtask
    // Queues the expectation
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
        expq.push_back(e);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic pulse(input int k);
        pls[k] <= 1'b1;
        @(posedge clock_i);
        pls[k] <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge clock_i) begin
        rd_seen <= rd;
        if (rd_seen) begin
            cmp("rdata", expq.pop_front(), rdata);
        end
    end
    initial begin
        #2000000;
        miscompares++;
        wrap_up();
    end
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        logic b;
        void'($urandom(79234));
        repeat (16) @(posedge clock_i);
        nrst_i <= 1'b1;
        @(posedge clock_i);
        rd_reg(vfd_pkg::REG_STAT, 8'h00);
        rd_reg(4'hf, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr_reg(vfd_pkg::REG_TXCMD, 8'(k));
            cmp("cmd_rw", {7'h00, k != 0}, {7'h00, cmd_rw});
        end
        wr_reg(vfd_pkg::REG_TXCMD, 8'h08);
        crc = vfd_pkg::CRC_INIT;
        pulse(0);
        cmp("phase", 8'h01, {5'h00, phase});
        for (int i = 0; i < 20; i++) begin
            if (i == 12) begin
                pulse(2);
                cmp("drive_en", 8'h01, {7'h00, drive_en});
            end
            b = 1'($urandom);
            tx_bit <= b;
            pulse(3);
            crc = {crc[13:0], 1'b0} ^ (b ^ crc[14] ? vfd_pkg::CRC_POLY : '0);
        end
        pulse(1);
        cmp("phase", 8'h03, {5'h00, phase});
        rd_reg(vfd_pkg::REG_CRCHI, {1'b0, ~crc[14:8]});
        rd_reg(vfd_pkg::REG_CRCLO, ~crc[7:0]);
        for (int i = 14; i >= 0; i--) begin
            cmp("fcs_bit", {7'h00, ~crc[i]}, {7'h00, fcs_bit});
            pulse(3);
        end
        for (int p = 4; p < 7; p++) begin
            cmp("phase", 8'(p), {5'h00, phase});
            pulse(2);
        end
        pulse(4);
        fault   <= 2'h2;
        bus_bit <= 1'b0;
        @(posedge clock_i);
        fault   <= 2'h0;
        bus_bit <= 1'b1;
        @(posedge clock_i);
        rd_reg(vfd_pkg::REG_STAT, 8'h04);
        rd_reg(vfd_pkg::REG_STAT, 8'h04);
        pulse(4);
        rd_reg(vfd_pkg::REG_STAT, 8'h00);
        // One silent wire
        for (int f = 1; f < 3; f++) begin
            fault <= 2'(f);
            repeat (6) begin
                bus_bit <= ~bus_bit;
                repeat (8) @(posedge clock_i);
            end
            rd_reg(vfd_pkg::REG_STAT, 8'h04 | 8'(f));
            fault <= 2'h0;
            pulse(4);
            rd_reg(vfd_pkg::REG_STAT, 8'h00);
        end
        // Ten dominant timeslots
        bus_bit <= 1'b0;
        repeat (40) @(posedge clock_i);
        bus_bit <= 1'b1;
        @(posedge clock_i);
        rd_reg(vfd_pkg::REG_STAT, 8'h03);
        pulse(4);
        rd_reg(vfd_pkg::REG_STAT, 8'h00);
        wrap_up();
    end
endmodule
